// [design/dual_adc_host.v]
// Purpose: host controller that runs the dual converter through its pins
// Assumes: converter busy and data arrive asynchronously to mclk
// Notes: one request yields one conversion and one pair of results, or only the first result when read-one is set with sleep, or no result on a busy timeout
`timescale 1ns/1ns
`include "dual_adc_host_defines.vh"

module dual_adc_host #(
    parameter BUSY_TIMEOUT = `BUSY_TIMEOUT_CYC
)
(
    input wire mclk,
    input wire rst_b,
    input wire start_req,
    input wire req_pair,
    input wire req_sleep,
    input wire req_read_one,
    input wire busy,
    input wire [13:0] adc_data_in,
    output reg conversion_start_n,
    output reg pair_select,
    output reg chip_select_n,
    output reg read_n,
    output reg idle,
    output reg result_valid,
    output reg [13:0] result_one,
    output reg [13:0] result_two,
    output reg result_pair,
    output reg timeout
);

// ----------------------------------------------------------------
// States
// ----------------------------------------------------------------
localparam [7:0] ST_IDLE = 8'h01;
localparam [7:0] ST_SETUP = 8'h02;
localparam [7:0] ST_START = 8'h04;
localparam [7:0] ST_CONV = 8'h08;
localparam [7:0] ST_RD1 = 8'h10;
localparam [7:0] ST_GAP = 8'h20;
localparam [7:0] ST_RD2 = 8'h40;
localparam [7:0] ST_QUIET = 8'h80;

reg [7:0] state;
reg [`CNT_W-1:0] cnt;
reg busy_m;
reg busy_s;
reg busy_seen;
reg [13:0] data_m;
reg [13:0] data_s;
reg sleep_mode;
reg one_only;

// Phase loads cut to the counter width; a load of N lasts N+1 cycles
localparam [31:0] SELECT_LOAD = `SELECT_CYC;
localparam [31:0] START_LOAD = `START_LOW_CYC;
// One less, so three strobe phases fit inside the fast read time
localparam [31:0] STROBE_LOAD = `STROBE_CYC - 1;
localparam [31:0] QUIET_LOAD = `QUIET_CYC;

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
// Two flops; data is stable by the time it is sampled late in a strobe
always @(posedge mclk or negedge rst_b)
begin
    if (!rst_b)
    begin
        busy_m <= 1'b0;
        busy_s <= 1'b0;
        data_m <= 14'h0000;
        data_s <= 14'h0000;
    end
    else
    begin
        busy_m <= busy;
        busy_s <= busy_m;
        data_m <= adc_data_in;
        data_s <= data_m;
    end
end

// ----------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------
// Counter reloads on each entry to a timed state; a zero count ends the phase
always @(posedge mclk or negedge rst_b)
begin
    if (!rst_b)
    begin
        state <= ST_IDLE;
        cnt <= {`CNT_W{1'b0}};
        conversion_start_n <= 1'b1;
        pair_select <= 1'b0;
        chip_select_n <= 1'b1;
        read_n <= 1'b1;
        idle <= 1'b1;
        result_valid <= 1'b0;
        result_one <= 14'h0000;
        result_two <= 14'h0000;
        result_pair <= 1'b0;
        timeout <= 1'b0;
        busy_seen <= 1'b0;
        sleep_mode <= 1'b0;
        one_only <= 1'b0;
    end
    else
    begin
        result_valid <= 1'b0;
        case (state)
            ST_IDLE:
            begin
                idle <= 1'b1;
                if (start_req)
                begin
                    // R15 select setup
                    pair_select <= req_pair;
                    sleep_mode <= req_sleep;
                    // R14 single result option
                    one_only <= req_read_one & req_sleep;
                    idle <= 1'b0;
                    timeout <= 1'b0;
                    cnt <= SELECT_LOAD[`CNT_W-1:0];
                    state <= ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                if (cnt == 0)
                begin
                    // R01 falling start edge
                    conversion_start_n <= 1'b0;
                    cnt <= START_LOAD[`CNT_W-1:0];
                    state <= ST_START;
                end
                else
                    cnt <= cnt - 1'b1;
            end
            ST_START:
            begin
                if (cnt == 0)
                begin
                    // R09 start low keeps auto-sleep
                    // Low through conversion end asks for auto-sleep
                    conversion_start_n <= ~sleep_mode;
                    busy_seen <= 1'b0;
                    cnt <= BUSY_TIMEOUT[`CNT_W-1:0];
                    state <= ST_CONV;
                end
                else
                    cnt <= cnt - 1'b1;
            end
            ST_CONV:
            begin
                // R02 busy rises after start
                if (busy_s)
                    busy_seen <= 1'b1;
                // R03 R12 wait for busy low
                if (busy_seen && !busy_s)
                begin
                    chip_select_n <= 1'b0;
                    read_n <= 1'b0;
                    // R07 four-cycle strobe phases
                    cnt <= STROBE_LOAD[`CNT_W-1:0];
                    state <= ST_RD1;
                end
                else if (cnt == 0)
                begin
                    timeout <= 1'b1;
                    conversion_start_n <= 1'b1;
                    state <= ST_IDLE;
                end
                else
                    cnt <= cnt - 1'b1;
            end
            ST_RD1:
            begin
                // R04 first pulse input one
                if (cnt == 0)
                begin
                    result_one <= data_s;
                    read_n <= 1'b1;
                    cnt <= STROBE_LOAD[`CNT_W-1:0];
                    state <= one_only ? ST_QUIET : ST_GAP;
                    if (one_only)
                    begin
                        chip_select_n <= 1'b1;
                        cnt <= QUIET_LOAD[`CNT_W-1:0];
                    end
                end
                else
                    cnt <= cnt - 1'b1;
            end
            ST_GAP:
            begin
                if (cnt == 0)
                begin
                    read_n <= 1'b0;
                    cnt <= STROBE_LOAD[`CNT_W-1:0];
                    state <= ST_RD2;
                end
                else
                    cnt <= cnt - 1'b1;
            end
            ST_RD2:
            begin
                // R05 second strobe inside select
                if (cnt == 0)
                begin
                    result_two <= data_s;
                    read_n <= 1'b1;
                    chip_select_n <= 1'b1;
                    cnt <= QUIET_LOAD[`CNT_W-1:0];
                    state <= ST_QUIET;
                end
                else
                    cnt <= cnt - 1'b1;
            end
            ST_QUIET:
            begin
                // R06 quiet time before next start
                if (cnt == 0)
                begin
                    // R10 rising start wakes converter
                    conversion_start_n <= 1'b1;
                    result_valid <= 1'b1;
                    result_pair <= pair_select;
                    state <= ST_IDLE;
                end
                else
                    cnt <= cnt - 1'b1;
            end
            default:
            begin
                state <= ST_IDLE;
            end
        endcase
    end
end

endmodule // dual_adc_host

// [design/dual_adc_host_defines.vh]
// Purpose: constants for the dual converter read controller
// Assumes: mclk at 125 MHz (8 ns period)
// Notes: times are kept in ns; cycle counts derive from them
// Operation
// R01 - Start falling edge holds and starts both
// R02 - Start falling edge raises busy
// R03 - Busy falls within 5.2 us, results latched
// R04 - First read input one, second input two
// R05 - One chip select enclosing two read pulses
// R06 - Read ends 400 ns before next start
// R07 - Fast read 100 ns, cycle 5.7 us
// R08 - Auto-sleep after busy falls, wake later
// R09 - Start level at conversion end selects mode
// R10 - Start rising edge wakes sleeping converter
// R11 - After wake, hold if start low, convert
// R12 - Late start falling edge: wait on busy
// R13 - Stored results readable while asleep
// R14 - Auto-sleep may read one pair only
// R15 - Pair select changes 500 ns before start
// R16 - Bipolar two's complement, unipolar straight binary
// R17 - Converter drives bus only during read
`ifndef DUAL_ADC_HOST_DEFINES_VH
`define DUAL_ADC_HOST_DEFINES_VH

`define CLK_PERIOD_NS 8
`define DATA_W 14
`define CONV_TIME_NS 5200
`define QUIET_TIME_NS 400
`define SELECT_SETUP_NS 500
`define READ_TIME_NS 100
`define WAKE_EXT_NS 4800
`define WAKE_INT_NS 5000000
`define START_LOW_NS 40
// Least times round up
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define QUIET_CYC `CYC_UP(`QUIET_TIME_NS)
`define SELECT_CYC `CYC_UP(`SELECT_SETUP_NS)
`define START_LOW_CYC `CYC_UP(`START_LOW_NS)
// Read strobe phase: a quarter of the fast read time, three phases a read
`define STROBE_CYC `CYC_UP(`READ_TIME_NS / 4)
// Busy timeout: longest conversion after wake, internal reference
`define BUSY_TIMEOUT_NS 5005000
`define BUSY_TIMEOUT_CYC `CYC_UP(`BUSY_TIMEOUT_NS)
`define CNT_W 20

`endif

// [testbench/dual_adc_host_checker.sv]
// Purpose: pin timing checks on the converter host
// Assumes: bound to dual_adc_host ports
// Notes: cs_hi and sel_age saturate, so long gaps read as max
`timescale 1ns/1ns
module dual_adc_host_checker #(parameter BUSY_TIMEOUT = 2000)(
    input wire mclk,
    input wire rst_b,
    input wire start_req,
    input wire req_sleep,
    input wire busy,
    input wire conversion_start_n,
    input wire pair_select,
    input wire chip_select_n,
    input wire read_n,
    input wire idle,
    input wire result_valid
);
logic [5:0] cs_hi;
logic [6:0] sel_age;
logic [3:0] cs_lo;
logic sel_q;
logic sleep_m;
// ----------------------------------------
// Ages of the read window and pair select
// ----------------------------------------
// Saturate so an idle bench never wraps into a false short gap
always @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
        cs_hi <= 6'h3f;
        sel_age <= 7'h7f;
        cs_lo <= 4'h0;
        sel_q <= 1'b0;
        sleep_m <= 1'b0;
    end
    else
    begin
        cs_hi <= !chip_select_n ? 6'h00 : (&cs_hi ? cs_hi : cs_hi + 6'h01);
        cs_lo <= chip_select_n ? 4'h0 : cs_lo + 4'h1;
        sel_age <= (pair_select != sel_q) ? 7'h00 :
            (&sel_age ? sel_age : sel_age + 7'h01);
        sel_q <= pair_select;
        if (start_req && idle)
            sleep_m <= req_sleep;
    end
default clocking cb @(posedge mclk); endclocking
default disable iff (!rst_b);
rd_in_cs_a: assert property (!read_n |-> !chip_select_n)
    else $error("read strobe outside chip select");
strobe_shape_a: assert property ($fell(chip_select_n)
    |-> (!read_n)[*4] ##1 read_n) else $error("first strobe not 4 cycles");
read_time_a: assert property (cs_lo <= 4'hc)
    else $error("read longer than fast read time");
quiet_time_a: assert property ($fell(conversion_start_n)
    |-> cs_hi >= 6'h32) else $error("start too soon after read");
sel_setup_a: assert property ($fell(conversion_start_n)
    |-> sel_age >= 7'h3e) else $error("pair select changed too late");
mode_level_a: assert property ($fell(busy)
    |-> conversion_start_n == !sleep_m) else $error("wrong start level");
sleep_end_c: cover property ($fell(busy) && sleep_m);
norm_end_c: cover property ($fell(busy) && !sleep_m);
pair_b_c: cover property (result_valid && pair_select);
endmodule // dual_adc_host_checker
bind dual_adc_host dual_adc_host_checker #(.BUSY_TIMEOUT(BUSY_TIMEOUT)) chk_i (
    .mclk(mclk), .rst_b(rst_b), .start_req(start_req), .busy(busy),
    .req_sleep(req_sleep), .conversion_start_n(conversion_start_n),
    .pair_select(pair_select), .chip_select_n(chip_select_n),
    .read_n(read_n), .idle(idle), .result_valid(result_valid));

// [testbench/dual_adc_host_tb.sv]
// Purpose: self-checking bench for dual_adc_host
// Assumes: converter model with external reference
// Notes: busy timeout cut to 2000 cycles to keep runs short
`timescale 1ns/1ns
module dual_adc_host_tb;
logic mclk = 0;
logic rst_b = 0;
logic start_req = 0;
logic req_pair = 0;
logic req_sleep = 0;
logic req_read_one = 0;
logic [13:0] vin [0:3];
logic [15:0] lf = 16'h0053;
logic [29:0] exp_q [$];
logic [29:0] e;
int n_mismatch = 0;
int total_checks = 0;
int tn = 0;
wire busy, conversion_start_n, pair_select, chip_select_n, read_n;
wire idle, result_valid, result_pair, timeout;
wire [13:0] adc_data_in, result_one, result_two;
dual_adc_host #(.BUSY_TIMEOUT(2000)) dual_adc_host_i (
    .mclk(mclk), .rst_b(rst_b), .start_req(start_req), .req_pair(req_pair),
    .req_sleep(req_sleep), .req_read_one(req_read_one), .busy(busy),
    .adc_data_in(adc_data_in), .conversion_start_n(conversion_start_n),
    .pair_select(pair_select), .chip_select_n(chip_select_n),
    .read_n(read_n), .idle(idle), .result_valid(result_valid),
    .result_one(result_one), .result_two(result_two),
    .result_pair(result_pair), .timeout(timeout));
dual_adc_model dual_adc_model_i (
    .conversion_start_n(conversion_start_n), .pair_select(pair_select),
    .chip_select_n(chip_select_n), .read_n(read_n), .vin(vin),
    .busy(busy), .adc_data(adc_data_in));
// -------------------------------
// Stimulus and result checking
// -------------------------------
function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
endfunction
task automatic chk(input logic [13:0] g, input logic [13:0] x);
    total_checks++;
    if (g !== x)
    begin
        n_mismatch++;
        $display("[ERR] %0t value %h expected %h", $time, g, x);
    end
endtask
task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
// One request, new inputs, note the expected pair; waits for idle
task automatic run_op(input logic p, input logic s, input logic o);
    int k;
    for (k = 0; k < 4; k++)
    begin
        lf = lfsr(lf);
        vin[k] = lf[13:0];
    end
    exp_q.push_back({o, p, vin[{p, 1'b0}], vin[{p, 1'b1}]});
    {req_pair, req_sleep, req_read_one, start_req} = {p, s, o, 1'b1};
    @(negedge mclk);
    start_req = 0;
    repeat (2) @(negedge mclk);
    for (k = 0; k < 3000 && idle !== 1'b1; k++)
        @(negedge mclk);
    tn++;
    $display("test %0d done", tn);
endtask
// Oldest note against each result pulse
always @(negedge mclk)
    if (result_valid === 1'b1)
    begin
        if (exp_q.size() == 0)
        begin
            n_mismatch++;
            $display("[ERR] %0t result with no request noted", $time);
        end
        e = exp_q.pop_front();
        chk({13'h0000, result_pair}, {13'h0000, e[28]});
        chk(result_one, e[27:14]);
        if (!e[29])
            chk(result_two, e[13:0]);
    end
initial forever #4 mclk = ~mclk;
// Hang guard, well above the dozen conversions run
initial
begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
end
initial
begin
    foreach (vin[k]) vin[k] = 14'h0000;
    repeat (10) @(negedge mclk);
    rst_b = 1;
    @(negedge mclk);
    run_op(0, 0, 0);
    run_op(1, 0, 0);
    run_op(0, 1, 0);
    run_op(1, 1, 0);
    run_op(0, 1, 1);
    repeat (700) @(negedge mclk);
    run_op(1, 0, 0);
    repeat (6)
    begin
        lf = lfsr(lf);
        run_op(lf[0], lf[1], lf[1] & lf[2]);
    end
    repeat (20) @(negedge mclk);
    chk({13'h0000, timeout}, 14'h0000);
    chk(14'(exp_q.size()), 14'h0000);
    print_verdict();
end
endmodule // dual_adc_host_tb

// [testbench/dual_adc_model.sv]
// Purpose: behavioural dual converter seen from its pins
// Assumes: external reference, times in ns
// Notes: a released bus shows the inverse word, never a held value
`timescale 1ns/1ns
module dual_adc_model #(parameter WAKE_NS = 4800)(
    input wire conversion_start_n,
    input wire pair_select,
    input wire chip_select_n,
    input wire read_n,
    input wire [13:0] vin [0:3],
    output logic busy,
    output logic [13:0] adc_data
);
logic asleep = 0;
logic pend = 0;
logic idx = 0;
logic [13:0] word [0:1] = '{14'h0000, 14'h0000};
initial busy = 0;
// -------------------------------
// Conversion, sleep and bus
// -------------------------------
// hold, convert, sleep
task automatic convert;
    busy = 1;
    pend = 0;
    word[0] = vin[{pair_select, 1'b0}];
    word[1] = vin[{pair_select, 1'b1}];
    #5200 busy = 0;
    idx = 0;
    asleep = !conversion_start_n;
endtask
always @(negedge conversion_start_n)
    if (!asleep)
        convert();
    else
    begin
        busy = 1;
        pend = 1;
    end
always @(posedge conversion_start_n)
    if (asleep)
    begin
        #WAKE_NS asleep = 0;
        if (pend)
            convert();
    end
assign adc_data = (!chip_select_n && !read_n) ? word[idx] : ~word[idx];
always @(posedge read_n)
    if (!chip_select_n)
        idx = 1;
endmodule // dual_adc_model
